//--- sarsr_core.sv
`timescale 1ns/1ps
// How it works
// [R1] A frame lasts 16 serial clocks: 4 hold clocks, then 12 decisions.
// [R2] Each decision clock tests one result bit against the held sample.
// [R3] Host keeps chip select high at least 62.5 ns between frames.
// [R4] Host samples each output bit on the falling edge ending it.
// [R5] Output format is unsigned or signed, fixed by a parameter.
// [R6] Mid-scale input gives 0h000 signed, 0h100 unsigned.
// [R7] Each frame shifts out the result of the previous conversion.
// [R8] Chip select falling ends acquisition and starts conversion.
// [R9] Result goes out MSB first, driven only while chip select is low.
module sarsr_core
    import sarsr_pkg::*;
#(
    parameter bit SIGNED_OUT = 1'b0,
    parameter int DEPTH      = FIFO_DEPTH
) (
    input  wire logic        clk,             // 100 MHz system clock
    input  wire logic        reset,           // Async reset, high
    input  wire logic        chip_select_n,   // Frame select pin, low
    input  wire logic        serial_clk,      // Serial clock pin
    input  wire logic [11:0] sample_in,       // Input sample code
    output logic             serial_data_out, // Serial result
    output logic             serial_data_oe,  // Output enable
    output logic [11:0]      result_data,     // Converted word
    output logic             result_valid,    // Result word available
    input  wire logic        result_ready,    // Result consumer ready
    output logic             acq_short        // Acquisition too brief
);
    logic [2:0]   cs_sync;
    logic [2:0]   sck_sync;
    logic         cs_fall;
    logic         sck_fall;
    logic         sck_rise;
    sarsr_state_e state;
    sarsr_state_e next_state;
    logic [4:0]   clk_cnt;
    logic [4:0]   next_clk_cnt;
    logic [11:0]  held;
    logic [11:0]  next_held;
    logic [11:0]  trial;
    logic [11:0]  next_trial;
    logic [11:0]  sar;
    logic [11:0]  next_sar;
    logic [11:0]  shift;
    logic [11:0]  next_shift;
    logic [11:0]  last_code;
    logic [11:0]  next_last_code;
    logic         dout;
    logic         next_dout;
    logic [3:0]   acq_cnt;
    logic [3:0]   next_acq_cnt;
    logic         next_acq_short;
    logic         done;
    logic         fifo_in_ready;
    logic [11:0]  fmt_code;
    // Variant's output for a mid-scale sample
    localparam logic [11:0] MID_CODE =
        SIGNED_OUT ? SIGNED_MID_CODE : UNSIGNED_MID_CODE; // [R5]

    // First stage only feeds second; edges use stages 1..2 after sync
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cs_sync  <= 3'h7;
            sck_sync <= 3'h0;
        end
        else
        begin
            cs_sync  <= {cs_sync[1:0], chip_select_n};
            sck_sync <= {sck_sync[1:0], serial_clk};
        end
    end

    always_comb
    begin
        cs_fall  = cs_sync[2] && !cs_sync[1];         // [R8]
        sck_fall = sck_sync[2] && !sck_sync[1];
        sck_rise = !sck_sync[2] && sck_sync[1];
    end

    always_comb
    begin
        next_state     = state;
        next_clk_cnt   = clk_cnt;
        next_held      = held;
        next_trial     = trial;
        next_sar       = sar;
        next_shift     = shift;
        next_last_code = last_code;
        next_dout      = dout;
        next_acq_cnt   = acq_cnt;
        next_acq_short = acq_short;
        done           = 1'b0;
        if (cs_sync[1] && acq_cnt != 4'(ACQ_CYCLES))
            next_acq_cnt = acq_cnt + 4'h1;
        unique case (state)
            SARSR_IDLE:
            begin
                if (cs_fall)
                begin
                    next_acq_short = acq_cnt < 4'(ACQ_CYCLES);
                    next_acq_cnt   = 4'h0;
                    next_state     = SARSR_HOLD;          // [R8]
                    next_clk_cnt   = 5'h0;
                    next_held      = sample_in;
                    next_sar       = 12'h000;
                    next_trial     = 12'h800;
                    next_shift     = last_code;           // [R7]
                    next_dout      = last_code[11];       // [R9]
                end
            end
            SARSR_HOLD, SARSR_DECIDE:
            begin
                if (cs_sync[1])
                    next_state = SARSR_IDLE;
                else
                begin
                    if (sck_fall)
                    begin
                        next_shift = {shift[10:0], 1'b0}; // [R9]
                        next_dout  = shift[10];
                    end
                    if (sck_rise)
                    begin
                        next_clk_cnt = clk_cnt + 5'h1;
                        if (clk_cnt == 5'(HOLD_CLOCKS - 1))
                            next_state = SARSR_DECIDE;    // [R1]
                        if (state == SARSR_DECIDE)
                        begin
                            // Keep the trial bit if held sample is not below
                            if (held >= (sar | trial))    // [R2]
                                next_sar = sar | trial;
                            next_trial = trial >> 1;
                            if (clk_cnt == 5'(FRAME_CLOCKS - 1))
                                next_state = SARSR_IDLE;  // [R1]
                        end
                    end
                end
            end
            default: next_state = SARSR_IDLE;
        endcase
        // Formatted from next_sar so the last decision is included
        fmt_code = next_sar - 12'h800 + MID_CODE;         // [R6]
        if (state == SARSR_DECIDE && next_state == SARSR_IDLE
            && next_clk_cnt == 5'(FRAME_CLOCKS))
        begin
            done           = 1'b1;
            next_last_code = fmt_code;                    // [R7]
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state     <= SARSR_IDLE;
            clk_cnt   <= 5'h0;
            held      <= 12'h000;
            trial     <= 12'h000;
            sar       <= 12'h000;
            shift     <= 12'h000;
            last_code <= 12'h000;
            dout      <= 1'b0;
            acq_cnt   <= 4'h0;
            acq_short <= 1'b0;
        end
        else
        begin
            state     <= next_state;
            clk_cnt   <= next_clk_cnt;
            held      <= next_held;
            trial     <= next_trial;
            sar       <= next_sar;
            shift     <= next_shift;
            last_code <= next_last_code;
            dout      <= next_dout;
            acq_cnt   <= next_acq_cnt;
            acq_short <= next_acq_short;
        end
    end

    always_comb
    begin
        serial_data_oe  = state != SARSR_IDLE;            // [R9]
        serial_data_out = serial_data_oe ? dout : 1'b0;
    end

    sarsr_fifo #(
        .WIDTH (12),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_data   (fmt_code),
        .in_valid  (done),
        .in_ready  (fifo_in_ready),
        .out_data  (result_data),
        .out_valid (result_valid),
        .out_ready (result_ready)
    );

    sequence s_frame_start;
        state == SARSR_IDLE && cs_fall;
    endsequence

    chk_start_hold: assert property ( // [R8]
        @(posedge clk) disable iff (reset)
        s_frame_start |=> state == SARSR_HOLD && clk_cnt == 5'h0)
        else $error("frame did not start on select fall");

    chk_abort_idle: assert property ( // [R8]
        @(posedge clk) disable iff (reset)
        state != SARSR_IDLE && cs_sync[1] |=> state == SARSR_IDLE)
        else $error("frame not ended on select rise");

    chk_shift_loads: assert property ( // [R7]
        @(posedge clk) disable iff (reset)
        s_frame_start |=> shift == $past(last_code))
        else $error("shift not loaded from previous result");

    chk_hold_len: assert property ( // [R1]
        @(posedge clk) disable iff (reset)
        $rose(state == SARSR_DECIDE) |-> clk_cnt == 5'(HOLD_CLOCKS))
        else $error("hold phase wrong length");

    chk_trial_walk: assert property ( // [R2]
        @(posedge clk) disable iff (reset)
        state == SARSR_DECIDE && sck_rise && !cs_sync[1]
        |=> trial == $past(trial) >> 1)
        else $error("trial bit did not step");

    chk_sar_bounded: assert property ( // [R2]
        @(posedge clk) disable iff (reset)
        state == SARSR_DECIDE |-> sar <= held)
        else $error("approximation above held sample");

    chk_oe_idle: assert property ( // [R9]
        @(posedge clk) disable iff (reset)
        cs_sync[2] |-> !serial_data_oe)
        else $error("output driven while deselected");

    chk_msb_first: assert property ( // [R9]
        @(posedge clk) disable iff (reset)
        s_frame_start |=> serial_data_out == $past(last_code[11]))
        else $error("first bit not MSB");

    chk_mid_code: assert property ( // [R6]
        @(posedge clk) disable iff (reset)
        done && next_sar == 12'h800 |-> fmt_code == MID_CODE)
        else $error("mid-scale code wrong");

    chk_push_room: assert property ( // [R7]
        @(posedge clk) disable iff (reset)
        done && fifo_in_ready |=> result_valid)
        else $error("result lost from buffer");
endmodule

//--- sarsr_pkg.sv
package sarsr_pkg;
    localparam int          RESULT_BITS       = 12;
    localparam int          FRAME_CLOCKS      = 16;
    localparam int          HOLD_CLOCKS       = FRAME_CLOCKS - RESULT_BITS;
    localparam int          CLK_PERIOD_PS     = 10000;
    localparam int          ACQUISITION_TIME_PS = 62500;
    localparam int          OUTPUT_VALID_DELAY_PS = 30000;
    localparam int          ACQ_CYCLES        =
        (ACQUISITION_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [11:0] SIGNED_MID_CODE   = 12'h000;
    localparam logic [11:0] UNSIGNED_MID_CODE = 12'h100;
    localparam int          FIFO_DEPTH        = 32;
    typedef enum logic [1:0] {SARSR_IDLE, SARSR_HOLD, SARSR_DECIDE}
        sarsr_state_e;
endpackage

//--- sarsr_fifo.sv
`timescale 1ns/1ps
module sarsr_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,       // System clock
    input  wire logic             reset,     // Async reset, high
    input  wire logic [WIDTH-1:0] in_data,   // Write data
    input  wire logic             in_valid,  // Write request
    output logic                  in_ready,  // Not full
    output logic      [WIDTH-1:0] out_data,  // Head word
    output logic                  out_valid, // Not empty
    input  wire logic             out_ready  // Read accept
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      next_rd_ptr;
    logic             push;
    logic             pop;

    always_comb
    begin
        in_ready    = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
        out_valid   = wr_ptr != rd_ptr;
        push        = in_valid && in_ready;
        pop         = out_valid && out_ready;
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        out_data    = mem[rd_ptr[AW-1:0]];
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr[AW-1:0]] <= in_data;
    end
endmodule

//--- sarsr_host.sv
`timescale 1ns/1ps
module sarsr_host (
    input  wire logic clk,             // Pacing clock
    output logic      chip_select_n,   // Frame select, low
    output logic      serial_clk,      // Serial clock, idles low
    input  wire logic serial_data_out  // Device data
);
    localparam int HALF = 8;

    initial
    begin
        chip_select_n = 1'b1;
        serial_clk    = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Select high for gap clocks, then nrise serial clocks
    task automatic frame(input int gap, input int nrise,
                         output logic [15:0] bits);
        bits = '0;
        wait_clk(gap);
        chip_select_n = 1'b0;
        wait_clk(HALF);
        for (int i = 0; i < nrise; i++)
        begin
            serial_clk = 1'b1;
            wait_clk(HALF);
            serial_clk = 1'b0;
            bits = {bits[14:0], serial_data_out};
            wait_clk(HALF);
        end
        chip_select_n = 1'b1;
    endtask
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import sarsr_pkg::*;
    logic        clk;
    logic        reset;
    logic        chip_select_n;
    logic        serial_clk;
    logic [11:0] sample_in;
    logic        serial_data_out;
    logic        serial_data_oe;
    logic [11:0] result_data;
    logic        result_valid;
    logic        result_ready;
    logic        acq_short;
    logic [11:0] sg_result_data;
    int          err_total;
    int          compares;
    logic [15:0] bits;
    logic [11:0] prev;

    sarsr_core #(.SIGNED_OUT(1'b0), .DEPTH(FIFO_DEPTH)) sarsr_core_inst (
        .clk(clk), .reset(reset), .chip_select_n(chip_select_n),
        .serial_clk(serial_clk), .sample_in(sample_in),
        .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
        .result_data(result_data), .result_valid(result_valid),
        .result_ready(result_ready), .acq_short(acq_short));

    // Signed variant sees the same frames, for the format check
    if (1)
    begin : g_signed
        sarsr_core #(.SIGNED_OUT(1'b1), .DEPTH(FIFO_DEPTH)) sarsr_core_inst (
            .clk(clk), .reset(reset), .chip_select_n(chip_select_n),
            .serial_clk(serial_clk), .sample_in(sample_in),
            .serial_data_out(), .serial_data_oe(), .result_data(sg_result_data),
            .result_valid(), .result_ready(result_ready), .acq_short());
    end

    sarsr_host sarsr_host_inst (
        .clk(clk), .chip_select_n(chip_select_n),
        .serial_clk(serial_clk), .serial_data_out(serial_data_out));

    always #5 clk = ~clk;

    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Sample is offset binary; 12'h800 lands on the variant's mid code
    function automatic logic [11:0] code(input logic [11:0] s, input bit sg);
        code = s - 12'h800 + (sg ? SIGNED_MID_CODE : UNSIGNED_MID_CODE);
    endfunction

    task automatic pop(input logic [11:0] s);
        int n;
        n = 0;
        while (result_valid !== 1'b1 && n < 50)
        begin
            step(1);
            n++;
        end
        if (result_valid !== 1'b1)
        begin
            err_total++;
            results();
        end
        chk("result", {4'h0, result_data}, {4'h0, code(s, 1'b0)});
        chk("signed", {4'h0, sg_result_data}, {4'h0, code(s, 1'b1)});
        result_ready = 1'b1;
        step(1);
        result_ready = 1'b0;
        step(1);
    endtask

    task automatic run(input logic [11:0] s);
        sample_in = s;
        sarsr_host_inst.frame(10, FRAME_CLOCKS, bits);
        chk("shift", bits, {prev, 4'h0});
        prev = code(s, 1'b0);
    endtask

    task automatic test_latency();
        logic [11:0] s [4];
        s = '{12'hA5C, 12'h001, 12'hFFF, 12'h800};
        chk("oe idle", {15'h0, serial_data_oe}, 16'h0000);
        for (int i = 0; i < 4; i++)
            run(s[i]);
        chk("oe after", {15'h0, serial_data_oe}, 16'h0000);
        for (int i = 0; i < 4; i++)
            pop(s[i]);
        $display("test latency done");
    endtask

    task automatic test_fill();
        for (int i = 0; i <= FIFO_DEPTH; i++)
            run(12'h0F0 + 12'(i));
        for (int i = 0; i < FIFO_DEPTH; i++)
            pop(12'h0F0 + 12'(i));
        step(2);
        chk("drained", {15'h0, result_valid}, 16'h0000);
        $display("test fill done");
    endtask

    task automatic test_acq();
        sarsr_host_inst.frame(10, FRAME_CLOCKS, bits);
        sarsr_host_inst.frame(3, FRAME_CLOCKS, bits);
        chk("short gap", {15'h0, acq_short}, 16'h0001);
        sarsr_host_inst.frame(ACQ_CYCLES, FRAME_CLOCKS, bits);
        chk("full gap", {15'h0, acq_short}, 16'h0000);
        for (int i = 0; i < 3; i++)
            pop(sample_in);
        $display("test acq done");
    endtask

    task automatic test_abort();
        sample_in = 12'h3C3;
        sarsr_host_inst.frame(10, 5, bits);
        step(10);
        chk("abort", {15'h0, result_valid}, 16'h0000);
        sarsr_host_inst.frame(10, FRAME_CLOCKS, bits);
        pop(12'h3C3);
        $display("test abort done");
    endtask

    initial
    begin
        clk = 1'b0;
        reset = 1'b1;
        sample_in = 12'h000;
        result_ready = 1'b0;
        err_total = 0;
        compares = 0;
        prev = 12'h000;
        step(8);
        reset = 1'b0;
        step(2);
        test_latency();
        test_fill();
        test_acq();
        test_abort();
        results();
    end
endmodule
